// ### verilog/data_eeprom_access_control.sv
// Data EEPROM access controller with I/O registers and self-timed write
`timescale 1ns/10ps
`default_nettype none

module data_eeprom_access_control #(
  parameter int WRITE_RC_CYCLES = nv_pkg::WRITE_RC_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire nv_pkg::io_req_s io_i,
  input wire logic global_irq_en_i,
  input wire logic selfprog_busy_i,
  output logic [7:0] io_rdata_o,
  output logic cpu_stall_o,
  output logic ready_irq_o
);

  ////////////////////////////////////////////////////////////////
  // Storage and register state

  logic [7:0] mem [nv_pkg::DEPTH];

  nv_pkg::ctrl_s ctrl, next_ctrl;
  logic [10:0] nv_address, next_nv_address;
  logic [7:0] nv_data, next_nv_data;
  logic [2:0] arm_cnt, next_arm_cnt;
  logic [2:0] stall_cnt, next_stall_cnt;
  logic [7:0] rdata, next_rdata;
  logic irq, next_irq;

  nv_pkg::wstate_e wstate, next_wstate;
  logic [10:0] wr_addr, next_wr_addr;
  logic [7:0] wr_byte, next_wr_byte;
  logic [4:0] div_cnt, next_div_cnt;
  logic [13:0] rc_cnt, next_rc_cnt;
  logic commit;

  function automatic logic hit(
    input nv_pkg::io_req_s r,
    input logic [5:0] off
  );
    hit = r.addr == off;
  endfunction

  logic wr_ctrl;
  logic wr_data;
  logic wr_alo;
  logic wr_ahi;
  logic busy;
  logic start_write;
  logic start_read;

  always_comb begin
    wr_ctrl = io_i.wr && hit(io_i, nv_pkg::OFF_CONTROL);
    wr_data = io_i.wr && hit(io_i, nv_pkg::OFF_DATA);
    wr_alo = io_i.wr && hit(io_i, nv_pkg::OFF_ADDR_LOW);
    wr_ahi = io_i.wr && hit(io_i, nv_pkg::OFF_ADDR_HIGH);
    busy = ctrl.wstrobe;
    start_write = wr_ctrl && io_i.wdata[nv_pkg::BIT_WRITE]
                  && ctrl.arm && !busy;
    start_read = wr_ctrl && io_i.wdata[nv_pkg::BIT_READ]
                 && !busy && !start_write;
  end

  ////////////////////////////////////////////////////////////////
  // Register file

  always_comb begin
    next_ctrl = ctrl;
    next_nv_address = nv_address;
    next_nv_data = nv_data;
    next_arm_cnt = arm_cnt;

    if (arm_cnt != 3'h0) begin
      next_arm_cnt = arm_cnt - 3'h1;
      if (arm_cnt == 3'h1) begin
        next_ctrl.arm = 1'b0;
      end
    end

    if (wr_ctrl) begin
      next_ctrl.rie = io_i.wdata[nv_pkg::BIT_RIE];
      // A fresh arm reloads the count, so it wins over expiry
      if (io_i.wdata[nv_pkg::BIT_ARM]) begin
        next_ctrl.arm = 1'b1;
        next_arm_cnt = nv_pkg::ARM_CYCLES;
      end
    end

    if (wr_alo && !busy) begin
      next_nv_address[7:0] = io_i.wdata;
    end
    if (wr_ahi && !busy) begin
      next_nv_address[10:8] = io_i.wdata[2:0];
    end
    if (wr_data) begin
      next_nv_data = io_i.wdata;
    end

    // data register takes the fetched byte
    if (start_read) begin
      next_nv_data = mem[nv_address];
    end

    // strobe held until done
    // Set wins: a start cannot meet a commit, busy blocks it
    if (start_write) begin
      next_ctrl.wstrobe = 1'b1;
    end else if (commit) begin
      next_ctrl.wstrobe = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl <= '0;
      nv_address <= nv_pkg::ADDR_RESET;
      nv_data <= nv_pkg::DATA_RESET;
      arm_cnt <= 3'h0;
    end else begin
      ctrl <= next_ctrl;
      nv_address <= next_nv_address;
      nv_data <= next_nv_data;
      arm_cnt <= next_arm_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Self-timed write engine

  logic rc_tick;

  always_comb begin
    next_wstate = wstate;
    next_wr_addr = wr_addr;
    next_wr_byte = wr_byte;
    next_div_cnt = div_cnt;
    next_rc_cnt = rc_cnt;
    commit = 1'b0;
    rc_tick = div_cnt == nv_pkg::RC_DIV - 5'h1;

    unique case (wstate)
      nv_pkg::ST_IDLE: begin
        // capture address and data at start
        if (start_write) begin
          next_wr_addr = nv_address;
          next_wr_byte = nv_data;
          next_wstate = nv_pkg::ST_HOLD;
        end
      end
      nv_pkg::ST_HOLD: begin
        // wait out flash self-programming
        // Strobe stays set while held, so software just polls longer
        if (!selfprog_busy_i) begin
          next_div_cnt = 5'h00;
          next_rc_cnt = 14'h0000;
          next_wstate = nv_pkg::ST_PROG;
        end
      end
      nv_pkg::ST_PROG: begin
        // time the write in 1 MHz ticks
        // Divider restarts per write; no tick phase is shared between writes
        next_div_cnt = rc_tick ? 5'h00 : div_cnt + 5'h1;
        if (rc_tick) begin
          next_rc_cnt = rc_cnt + 14'h0001;
          if (rc_cnt == 14'(WRITE_RC_CYCLES - 1)) begin
            commit = 1'b1;
            next_wstate = nv_pkg::ST_IDLE;
          end
        end
      end
      default: next_wstate = nv_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wstate <= nv_pkg::ST_IDLE;
      wr_addr <= nv_pkg::ADDR_RESET;
      wr_byte <= nv_pkg::DATA_RESET;
      div_cnt <= 5'h00;
      rc_cnt <= 14'h0000;
    end else begin
      wstate <= next_wstate;
      wr_addr <= next_wr_addr;
      wr_byte <= next_wr_byte;
      div_cnt <= next_div_cnt;
      rc_cnt <= next_rc_cnt;
    end
  end

  // Array holds no reset; contents are nonvolatile by intent
  always_ff @(posedge clk_i) begin
    if (commit) begin
      mem[wr_addr] <= wr_byte;
    end
  end

  ////////////////////////////////////////////////////////////////
  // CPU stall

  logic stall, next_stall;

  always_comb begin
    next_stall_cnt = stall_cnt;
    // write stall
    // An armed write wins when both strobes arrive in one control write
    if (start_write) begin
      next_stall_cnt = nv_pkg::WRITE_STALL;
    end else if (start_read) begin
      next_stall_cnt = nv_pkg::READ_STALL;
    end else if (stall_cnt != 3'h0) begin
      next_stall_cnt = stall_cnt - 3'h1;
    end
    // Taken from the next count so the halt starts right after the strobe edge
    next_stall = next_stall_cnt != 3'h0;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      stall_cnt <= 3'h0;
      stall <= 1'b0;
    end else begin
      stall_cnt <= next_stall_cnt;
      stall <= next_stall;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read-back and ready interrupt

  always_comb begin
    next_rdata = rdata;
    // upper control bits zero
    // Read strobe acts at once, so its bit always reads back as zero
    if (io_i.rd) begin
      unique case (io_i.addr)
        nv_pkg::OFF_CONTROL: next_rdata = {4'h0, ctrl.rie, ctrl.arm, ctrl.wstrobe, 1'b0};
        nv_pkg::OFF_DATA: next_rdata = nv_data;
        nv_pkg::OFF_ADDR_LOW: next_rdata = nv_address[7:0];
        nv_pkg::OFF_ADDR_HIGH: next_rdata = {5'h00, nv_address[10:8]};
        default: next_rdata = 8'h00;
      endcase
    end

    // level ready interrupt
    // Registered, so it trails the strobe by one cycle
    next_irq = ctrl.rie && global_irq_en_i && !ctrl.wstrobe;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata <= 8'h00;
      irq <= 1'b0;
    end else begin
      rdata <= next_rdata;
      irq <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs

  always_comb begin
    io_rdata_o = rdata;
    cpu_stall_o = stall;
    ready_irq_o = irq;
  end

endmodule

`default_nettype wire

// ### verilog/nv_pkg.sv
// Constants and types of the data EEPROM access controller
// Notes on behaviour
// - 2 Kbyte byte-wide nonvolatile data space
// - Read stalls CPU four clock cycles
// - Write start stalls CPU two cycles
// - Address bits 15..11 read as zero
// - Eleven-bit linear byte address from two registers
// - Data register feeds writes, receives reads
// - Control bits 7..4 read as zero
// - Ready interrupt while enabled and not writing
// - Armed strobe within four cycles starts write
// - Strobe without arm is ignored
// - Arm bit self-clears after four cycles
// - Write strobe stays set until write done
// - No programming while flash self-programming busy
// - Read strobe loads data register immediately
// - No read or address change while writing
// - Write lasts 8448 cycles of 1 MHz
`default_nettype none
package nv_pkg;

  localparam int ADDR_W = 11;
  localparam int DEPTH = 2048;
  localparam logic [5:0] OFF_CONTROL = 6'h1c;
  localparam logic [5:0] OFF_DATA = 6'h1d;
  localparam logic [5:0] OFF_ADDR_LOW = 6'h1e;
  localparam logic [5:0] OFF_ADDR_HIGH = 6'h1f;

  // Control register field positions
  localparam int BIT_READ = 0;
  localparam int BIT_WRITE = 1;
  localparam int BIT_ARM = 2;
  localparam int BIT_RIE = 3;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [10:0] ADDR_RESET = 11'h000;
  localparam logic [7:0] DATA_RESET = 8'h00;

  localparam logic [2:0] ARM_CYCLES = 3'h4;
  localparam logic [2:0] READ_STALL = 3'h4;
  localparam logic [2:0] WRITE_STALL = 3'h2;

  localparam int CLK_HZ = 25000000;
  localparam int RC_HZ = 1000000;
  localparam int WRITE_RC_CYCLES = 8448;
  localparam logic [4:0] RC_DIV = 5'(CLK_HZ / RC_HZ);

  typedef struct packed {
    logic [5:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } io_req_s;

  typedef struct packed {
    logic rie;
    logic arm;
    logic wstrobe;
  } ctrl_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HOLD = 3'b010,
    ST_PROG = 3'b100
  } wstate_e;

endpackage

`default_nettype wire

// ### sim/nv_props.sv
// Port checker of the data EEPROM access controller
`timescale 1ns/10ps
`default_nettype none
module nv_props (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire nv_pkg::io_req_s io_i,
  input wire logic global_irq_en_i,
  input wire logic selfprog_busy_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic cpu_stall_o,
  input wire logic ready_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic ctl_w = io_i.wr && io_i.addr == nv_pkg::OFF_CONTROL;
  unmapped_read_a: assert property (io_i.rd && io_i.addr[5:2] != 4'h7 |=> io_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  addr_high_zero_a: assert property (io_i.rd && io_i.addr == nv_pkg::OFF_ADDR_HIGH
    |=> io_rdata_o[7:3] == 5'h00) else $error("address high reserved bits set");
  ctrl_zero_a: assert property (io_i.rd && ctl_w == 1'b0 && io_i.addr == nv_pkg::OFF_CONTROL
    |=> io_rdata_o[7:4] == 4'h0) else $error("control reserved bits set");
  irq_gie_a: assert property (!global_irq_en_i |=> !ready_irq_o)
    else $error("interrupt without global enable");
  irq_off_a: assert property (ctl_w && !io_i.wdata[3] |=> ##1 !ready_irq_o)
    else $error("interrupt after enable cleared");
  read_stall_a: assert property ($rose(cpu_stall_o) && $past(ctl_w && io_i.wdata[1:0] == 2'h1)
    |-> cpu_stall_o [*4] ##1 !cpu_stall_o) else $error("read stall length wrong");
  write_stall_a: assert property ($rose(cpu_stall_o) && $past(ctl_w && io_i.wdata[1])
    |-> cpu_stall_o [*2] ##1 !cpu_stall_o) else $error("write stall length wrong");
  stall_cause_a: assert property ($rose(cpu_stall_o) |-> $past(ctl_w))
    else $error("stall without control write");
endmodule
bind data_eeprom_access_control nv_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .io_i(io_i),
  .global_irq_en_i(global_irq_en_i), .selfprog_busy_i(selfprog_busy_i), .io_rdata_o(io_rdata_o),
  .cpu_stall_o(cpu_stall_o), .ready_irq_o(ready_irq_o));
`default_nettype wire

// ### sim/nv_cpu_model.sv
// CPU core model issuing I/O register accesses
`timescale 1ns/10ps
`default_nettype none
module nv_cpu_model (
  input wire logic clk_i,
  input wire logic stall_i,
  input wire logic [7:0] rdata_i,
  output var nv_pkg::io_req_s io_o
);
  initial io_o = '0;
  task automatic xfer(input logic [5:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_i);
    while (stall_i) @(negedge clk_i);
    @(posedge clk_i);
    io_o <= {a, w, !w, d};
    @(posedge clk_i);
    io_o <= '0;
    @(negedge clk_i);
    q = rdata_i;
  endtask
endmodule
`default_nettype wire

// ### sim/data_eeprom_access_control_tb_top.sv
// Self-checking bench of the data EEPROM access controller
`timescale 1ns/10ps
`default_nettype none
module data_eeprom_access_control_tb_top;
  localparam logic [5:0] CTL = nv_pkg::OFF_CONTROL;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic gie = 1'b0;
  logic spb = 1'b0;
  nv_pkg::io_req_s io;
  logic [7:0] rdata;
  logic stall;
  logic irq;
  logic [7:0] q;
  logic [7:0] mem [2048];
  logic [10:0] a;
  int miscompares = 0;
  int cmp_count = 0;
  integer seed = 66;
  initial forever #20 clk_i = ~clk_i;
  data_eeprom_access_control #(.WRITE_RC_CYCLES(4)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .io_i(io),
    .global_irq_en_i(gie), .selfprog_busy_i(spb), .io_rdata_o(rdata), .cpu_stall_o(stall), .ready_irq_o(irq));
  nv_cpu_model cpu (.clk_i(clk_i), .stall_i(stall), .rdata_i(rdata), .io_o(io));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [7:0] ctl_word(input logic rie, input logic arm, input logic ws);
    ctl_word = {4'h0, rie, arm, ws, 1'b0};
  endfunction
  task automatic wr(input logic [5:0] r, input logic [7:0] d);
    cpu.xfer(r, 1'b1, d, q);
  endtask
  task automatic rd(input logic [5:0] r, input string n, input logic [7:0] e);
    cpu.xfer(r, 1'b0, 8'h00, q);
    chk(n, e, q);
  endtask
  task automatic seta(input logic [10:0] ad);
    wr(nv_pkg::OFF_ADDR_HIGH, {5'h00, ad[10:8]});
    wr(nv_pkg::OFF_ADDR_LOW, ad[7:0]);
  endtask
  // arm then strobe back to back
  task automatic wbyte(input logic [10:0] ad, input logic [7:0] d);
    seta(ad);
    wr(nv_pkg::OFF_DATA, d);
    wr(CTL, 8'h0c);
    wr(CTL, 8'h0a);
  endtask
  task automatic rbyte(input logic [10:0] ad, input logic [7:0] e);
    seta(ad);
    wr(CTL, 8'h09);
    rd(nv_pkg::OFF_DATA, "data byte", e);
  endtask
  task automatic poll;
    int n = 0;
    q = 8'h02;
    while (q[1] && n < 400) begin
      cpu.xfer(CTL, 1'b0, 8'h00, q);
      n++;
    end
    chk("write done", ctl_word(1'b1, 1'b0, 1'b0), q);
  endtask
  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(CTL, "control reset", nv_pkg::CONTROL_RESET);
    wr(nv_pkg::OFF_ADDR_HIGH, 8'hff);
    rd(nv_pkg::OFF_ADDR_HIGH, "address high", 8'h07);
    rd(6'h05, "unmapped", 8'h00);
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 11'h7ff : (i == 1) ? 11'h000 : 11'($random(seed));
      mem[a] = 8'($random(seed));
      @(posedge clk_i);
      gie <= 1'($random(seed));
      wbyte(a, mem[a]);
      // Interrupt flop trails the strobe by one cycle
      @(negedge clk_i);
      chk("irq in write", 8'h00, {7'h00, irq});
      poll();
      chk("irq ready", {7'h00, gie}, {7'h00, irq});
      rbyte(a, mem[a]);
    end
    wr(nv_pkg::OFF_DATA, ~mem[a]);
    wr(CTL, 8'h0a);
    rd(CTL, "strobe unarmed", ctl_word(1'b1, 1'b0, 1'b0));
    wr(CTL, 8'h0c);
    rd(CTL, "arm set", ctl_word(1'b1, 1'b1, 1'b0));
    repeat (6) @(posedge clk_i);
    rd(CTL, "arm expired", ctl_word(1'b1, 1'b0, 1'b0));
    wr(CTL, 8'h0a);
    rbyte(a, mem[a]);
    @(posedge clk_i);
    spb <= 1'b1;
    wbyte(a, 8'h5a);
    repeat (200) @(posedge clk_i);
    rd(CTL, "held by flash busy", ctl_word(1'b1, 1'b0, 1'b1));
    wr(nv_pkg::OFF_ADDR_LOW, ~a[7:0]);
    wr(nv_pkg::OFF_DATA, 8'ha5);
    wr(CTL, 8'h09);
    rd(nv_pkg::OFF_DATA, "read while busy", 8'ha5);
    @(posedge clk_i);
    spb <= 1'b0;
    poll();
    rd(nv_pkg::OFF_ADDR_LOW, "address kept", a[7:0]);
    rbyte(a, 8'h5a);
    @(posedge clk_i);
    gie <= 1'b1;
    wr(CTL, 8'h00);
    // Cleared enable reaches the pin two edges after the write
    repeat (2) @(negedge clk_i);
    chk("irq disabled", 8'h00, {7'h00, irq});
    summarize();
  end
  initial begin
    #2000000;
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
